// File: design/gpdi_pkg.sv
// ==========================================================
// gripper process data interface constants
package gpdi_pkg;
	// ======================================================
	// command word (master to device), sent high byte first
	localparam int             CMD_EN_BIT    = 9;
	localparam int             CMD_GRIP_BIT  = 8;
	localparam logic [15:0]    CMD_RSVD_MASK = 16'hFC00;
	localparam logic [15:0]    CMD_RESET     = 16'h0000;
	// ======================================================
	// status word (device to master), sent high byte first
	localparam int             STS_POS_LSB     = 16;
	localparam int             STS_SW_LSB      = 12;
	localparam int             STS_SERVICE_BIT = 7;
	localparam int             STS_TWARN_BIT   = 6;
	localparam int             STS_TERR_BIT    = 5;
	localparam int             STS_FAULT_BIT   = 4;
	localparam int             STS_HOLD_BIT    = 3;
	localparam int             STS_NOPART_BIT  = 2;
	localparam int             STS_REL_BIT     = 1;
	localparam int             STS_IDLE_BIT    = 0;
	localparam logic [31:0]    STS_RSVD_MASK   = 32'h0000_0F00;
	// ======================================================
	// temperatures in tenths of a degree
	localparam int             TWARN_LO  = 0;
	localparam int             TWARN_HI  = 550;
	localparam int             TWARN_HYS = 20;
	localparam int             TERR_SET  = 700;
	localparam int             TERR_CLR  = 680;
	// ======================================================
	// acyclic addressing
	localparam logic [15:0]    IDX_SYSCMD      = 16'h0002;
	localparam logic [15:0]    IDX_GRIP_BASE   = 16'h0060;
	localparam logic [15:0]    IDX_SWITCH_BASE = 16'h0090;
	localparam logic [15:0]    IDX_DIAG        = 16'h00A0;
	localparam logic [7:0]     SUB_FIRST       = 8'h01;
	localparam logic [7:0]     SUB_SECOND      = 8'h02;
	localparam logic [7:0]     SUB_TEMP        = 8'h03;
	localparam logic [7:0]     SYSCMD_SERVICE_ACK = 8'hA1;
	localparam logic [7:0]     SYSCMD_STORE       = 8'hA2;
	// ======================================================
	// parameter factory values
	localparam logic [15:0]    NOPART_DFLT   = 16'h0064;
	localparam logic [15:0]    RELEASE_DFLT  = 16'h044C;
	localparam logic [15:0]    SWPOS_DFLT    = 16'h0000;
	localparam logic [15:0]    SWWIDTH_DFLT  = 16'h00C8;
	localparam int             SERVICE_INTERVAL_DFLT = 1000000;
	// ======================================================
	// controller: cycle period in clocks and register offsets
	localparam int             MST_CYCLE_CLKS  = 400;
	localparam logic [7:0]     REG_CMD         = 8'h00;
	localparam logic [7:0]     REG_STATUS      = 8'h04;
	localparam logic [7:0]     REG_ACY_ADDR    = 8'h08;
	localparam logic [7:0]     REG_ACY_WDATA   = 8'h0C;
	localparam logic [7:0]     REG_ACY_CTRL    = 8'h10;
	localparam logic [7:0]     REG_ACY_RESULT  = 8'h14;
	localparam logic [7:0]     REG_FRAMES      = 8'h18;
endpackage : gpdi_pkg

// File: design/gpdi_if.sv
`timescale 1ns/100ps
// ==========================================================
// link between controller and gripper end
interface gpdi_if;
	logic        m2d_valid;
	logic        m2d_first;
	logic [7:0]  m2d_byte;
	logic        d2m_valid;
	logic [7:0]  d2m_byte;
	logic        acy_req;
	logic        acy_wr;
	logic [15:0] acy_index;
	logic [7:0]  acy_sub;
	logic [15:0] acy_wdata;
	logic        acy_ack;
	logic        acy_err;
	logic [15:0] acy_rdata;
	modport dev (
		input  m2d_valid, m2d_first, m2d_byte, acy_req, acy_wr, acy_index, acy_sub, acy_wdata,
		output d2m_valid, d2m_byte, acy_ack, acy_err, acy_rdata
	);
	modport mst (
		output m2d_valid, m2d_first, m2d_byte, acy_req, acy_wr, acy_index, acy_sub, acy_wdata,
		input  d2m_valid, d2m_byte, acy_ack, acy_err, acy_rdata
	);
endinterface : gpdi_if

// File: design/gpdi_device.sv
`timescale 1ns/100ps
module gpdi_device
	import gpdi_pkg::*;
#(
	parameter int SERVICE_INTERVAL = SERVICE_INTERVAL_DFLT
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// link to controller
	gpdi_if.dev                     link,
	// sensing from the gripper mechanics
	input  wire logic signed [15:0] jaw_pos,
	input  wire logic               jaw_blocked,
	input  wire logic signed [15:0] temp_dc,
	input  wire logic               fault_active,
	input  wire logic               grip_cycle_done,
	// actuation
	output logic                    valves_enable,
	output logic                    grip_request,
	output logic [1:0]              grip_set,
	output logic [15:0]             set_nopart_limit,
	output logic [15:0]             set_release_limit,
	// non-volatile memory
	input  wire logic               nvm_load,
	input  wire logic [255:0]       nvm_image,
	output logic                    nvm_store_req,
	output logic [255:0]            param_image
);
	// ======================================================
	// elaboration checks
	if (SERVICE_INTERVAL < 1) begin : g_chk
		$error("service interval must be at least one");
	end

	// ======================================================
	// state
	typedef struct packed {
		logic              rx_half;
		logic [7:0]        rx_hi;
		logic [15:0]       cmd;
		logic              cmd_new;
		logic              en;
		logic              grip;
		logic [1:0]        sel;
		logic [1:0]        set_used;
		logic [3:0][15:0]  nopart;
		logic [3:0][15:0]  rel_lim;
		logic [3:0][15:0]  sw_pos;
		logic [3:0][15:0]  sw_width;
		logic              warn;
		logic              terr;
		logic              service;
		logic [31:0]       svc_cnt;
		logic [31:0]       snap;
		logic [2:0]        tx_cnt;
		logic              tx_valid;
		logic [7:0]        tx_byte;
		logic              acy_ack;
		logic              acy_err;
		logic [15:0]       acy_rdata;
		logic              store;
	} gpdi_dev_st_t;

	gpdi_dev_st_t st_ff;
	gpdi_dev_st_t nxt_st;

	// ======================================================
	// helpers
	function automatic logic in_group(input logic [15:0] idx, input logic [15:0] base);
		in_group = (idx[15:2] == base[15:2]);
	endfunction : in_group

	function automatic logic in_window(input logic signed [15:0] pos,
	                                   input logic signed [15:0] ctr,
	                                   input logic [15:0]        width);
		logic signed [17:0] diff;
		logic        [17:0] mag;
		diff = 18'(pos) - 18'(ctr);
		mag = diff[17] ? 18'(-diff) : 18'(diff);
		in_window = (mag <= {3'b000, width[15:1]});
	endfunction : in_window

	// ======================================================
	// status word
	logic [31:0]        status_word;
	logic signed [15:0] lim_np;
	logic signed [15:0] lim_rel;

	always_comb begin
		lim_np  = st_ff.nopart[st_ff.set_used];
		lim_rel = st_ff.rel_lim[st_ff.set_used];
		status_word = 32'h0000_0000;
		status_word[STS_POS_LSB +: 16] = jaw_pos;
		for (int i = 0; i < 4; i++) begin
			status_word[STS_SW_LSB + i] = in_window(jaw_pos, st_ff.sw_pos[i],
			                                        st_ff.sw_width[i]);
		end
		status_word[STS_SERVICE_BIT] = st_ff.service;
		status_word[STS_TWARN_BIT]   = st_ff.warn;
		status_word[STS_TERR_BIT]    = st_ff.terr;
		status_word[STS_FAULT_BIT]   = fault_active;
		if (!st_ff.en) begin
			status_word[STS_IDLE_BIT] = 1'b1;
		end else if (st_ff.grip) begin
			// jaws close toward lower positions: no-part limit lies below release
			status_word[STS_HOLD_BIT]   = jaw_blocked && (jaw_pos > lim_np)
			                              && (jaw_pos < lim_rel);
			status_word[STS_NOPART_BIT] = (jaw_pos <= lim_np);
		end else begin
			status_word[STS_REL_BIT] = (jaw_pos >= lim_rel);
		end
	end

	// ======================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cmd_new  = 1'b0;
		nxt_st.tx_valid = 1'b0;
		nxt_st.acy_ack  = 1'b0;
		nxt_st.store    = 1'b0;

		// command reception, high byte first
		if (link.m2d_valid && link.m2d_first) begin
			nxt_st.rx_hi   = link.m2d_byte;
			nxt_st.rx_half = 1'b1;
		end else if (link.m2d_valid && st_ff.rx_half) begin
			nxt_st.cmd     = {st_ff.rx_hi, link.m2d_byte} & ~CMD_RSVD_MASK;
			nxt_st.rx_half = 1'b0;
			nxt_st.cmd_new = 1'b1;
			nxt_st.snap    = status_word;
			nxt_st.tx_cnt  = 3'd4;
		end

		// apply the command in the cycle after receipt
		if (st_ff.cmd_new) begin
			nxt_st.en   = st_ff.cmd[CMD_EN_BIT];
			nxt_st.grip = st_ff.cmd[CMD_GRIP_BIT];
			// out of range selectors keep the previous set
			if (st_ff.cmd[7:2] == 6'd0) begin
				nxt_st.sel = st_ff.cmd[1:0];
			end
		end
		// the set is taken over when a grip begins, not mid-grip
		if (nxt_st.en && nxt_st.grip && !(st_ff.en && st_ff.grip)) begin
			nxt_st.set_used = nxt_st.sel;
		end

		// status return, high byte first
		if (st_ff.tx_cnt != 3'd0) begin
			nxt_st.tx_valid = 1'b1;
			nxt_st.tx_byte  = st_ff.snap[31:24];
			nxt_st.snap     = {st_ff.snap[23:0], 8'h00};
			nxt_st.tx_cnt   = st_ff.tx_cnt - 3'd1;
		end

		// temperature flags
		if (temp_dc < TWARN_LO || temp_dc > TWARN_HI) begin
			nxt_st.warn = 1'b1;
		end else if (temp_dc >= TWARN_LO + TWARN_HYS && temp_dc <= TWARN_HI - TWARN_HYS) begin
			nxt_st.warn = 1'b0;
		end
		if (temp_dc > TERR_SET) begin
			nxt_st.terr = 1'b1;
		end else if (temp_dc < TERR_CLR) begin
			nxt_st.terr = 1'b0;
		end

		// maintenance counting saturates rather than wrapping to zero
		if (grip_cycle_done && st_ff.svc_cnt != 32'hFFFF_FFFF) begin
			nxt_st.svc_cnt = st_ff.svc_cnt + 32'h0000_0001;
		end
		if (nxt_st.svc_cnt >= 32'(SERVICE_INTERVAL)) begin
			nxt_st.service = 1'b1;
		end

		// acyclic access, answered one cycle after the request
		if (link.acy_req) begin
			nxt_st.acy_ack   = 1'b1;
			nxt_st.acy_err   = 1'b0;
			nxt_st.acy_rdata = 16'h0000;
			if (in_group(link.acy_index, IDX_GRIP_BASE)
			    && (link.acy_sub == SUB_FIRST || link.acy_sub == SUB_SECOND)) begin
				if (link.acy_sub == SUB_FIRST) begin
					nxt_st.acy_rdata = st_ff.nopart[link.acy_index[1:0]];
					if (link.acy_wr) begin
						nxt_st.nopart[link.acy_index[1:0]] = link.acy_wdata;
					end
				end else begin
					nxt_st.acy_rdata = st_ff.rel_lim[link.acy_index[1:0]];
					if (link.acy_wr) begin
						nxt_st.rel_lim[link.acy_index[1:0]] = link.acy_wdata;
					end
				end
			end else if (in_group(link.acy_index, IDX_SWITCH_BASE)
			             && (link.acy_sub == SUB_FIRST || link.acy_sub == SUB_SECOND)) begin
				if (link.acy_sub == SUB_FIRST) begin
					nxt_st.acy_rdata = st_ff.sw_pos[link.acy_index[1:0]];
					if (link.acy_wr) begin
						nxt_st.sw_pos[link.acy_index[1:0]] = link.acy_wdata;
					end
				end else begin
					nxt_st.acy_rdata = st_ff.sw_width[link.acy_index[1:0]];
					if (link.acy_wr) begin
						nxt_st.sw_width[link.acy_index[1:0]] = link.acy_wdata;
					end
				end
			end else if (link.acy_index == IDX_DIAG && link.acy_sub == SUB_TEMP
			             && !link.acy_wr) begin
				nxt_st.acy_rdata = temp_dc;
			end else if (link.acy_index == IDX_SYSCMD && link.acy_wr) begin
				if (link.acy_wdata[7:0] == SYSCMD_SERVICE_ACK) begin
					// the acknowledge restarts counting, so it wins over a pending set
					nxt_st.service = 1'b0;
					nxt_st.svc_cnt = 32'h0000_0000;
				end else if (link.acy_wdata[7:0] == SYSCMD_STORE) begin
					nxt_st.store = 1'b1;
				end else begin
					nxt_st.acy_err = 1'b1;
				end
			end else begin
				nxt_st.acy_err = 1'b1;
			end
		end

		// restore from non-volatile memory or a master download; last writer wins
		if (nvm_load) begin
			{nxt_st.nopart, nxt_st.rel_lim, nxt_st.sw_pos, nxt_st.sw_width} = nvm_image;
		end
	end

	// ======================================================
	// registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_ff          <= '0;
			st_ff.cmd      <= CMD_RESET;
			st_ff.nopart   <= {4{NOPART_DFLT}};
			st_ff.rel_lim  <= {4{RELEASE_DFLT}};
			st_ff.sw_pos   <= {4{SWPOS_DFLT}};
			st_ff.sw_width <= {4{SWWIDTH_DFLT}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================
	// outputs
	assign link.d2m_valid    = st_ff.tx_valid;
	assign link.d2m_byte     = st_ff.tx_byte;
	assign link.acy_ack      = st_ff.acy_ack;
	assign link.acy_err      = st_ff.acy_err;
	assign link.acy_rdata    = st_ff.acy_rdata;
	assign valves_enable     = st_ff.en;
	assign grip_request      = st_ff.en && st_ff.grip;
	assign grip_set          = st_ff.set_used;
	assign set_nopart_limit  = st_ff.nopart[st_ff.set_used];
	assign set_release_limit = st_ff.rel_lim[st_ff.set_used];
	assign nvm_store_req     = st_ff.store;
	assign param_image       = {st_ff.nopart, st_ff.rel_lim, st_ff.sw_pos, st_ff.sw_width};
endmodule : gpdi_device

// File: design/gpdi_master.sv
`timescale 1ns/100ps
module gpdi_master
	import gpdi_pkg::*;
#(
	parameter int CYCLE_CLKS = MST_CYCLE_CLKS
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// link to gripper
	gpdi_if.mst              link
);
	// ======================================================
	// elaboration checks
	if (CYCLE_CLKS < 8 || CYCLE_CLKS > 65536) begin : g_chk
		$error("cycle period must lie in 8..65536 clocks");
	end

	// ======================================================
	// state
	typedef struct packed {
		logic [15:0] cmd;
		logic [31:0] status;
		logic [15:0] frames;
		logic [15:0] timer;
		logic        send_lo;
		logic [7:0]  lo_byte;
		logic [1:0]  rx_cnt;
		logic [23:0] rx_shift;
		logic        m_valid;
		logic        m_first;
		logic [7:0]  m_byte;
		logic [23:0] acy_addr;
		logic [15:0] acy_wdata;
		logic        acy_req;
		logic        acy_wr;
		logic        acy_busy;
		logic        acy_err;
		logic [15:0] acy_rdata;
		logic        a_wr;
		logic [7:0]  a_addr;
		logic [31:0] rdata;
	} gpdi_mst_st_t;

	gpdi_mst_st_t st_ff;
	gpdi_mst_st_t nxt_st;

	function automatic logic [31:0] read_reg(input gpdi_mst_st_t s, input logic [7:0] a);
		case (a)
			REG_CMD:        read_reg = {16'h0000, s.cmd};
			REG_STATUS:     read_reg = s.status;
			REG_ACY_ADDR:   read_reg = {8'h00, s.acy_addr};
			REG_ACY_WDATA:  read_reg = {16'h0000, s.acy_wdata};
			REG_ACY_CTRL:   read_reg = {30'h0000_0000, s.acy_wr, s.acy_busy};
			REG_ACY_RESULT: read_reg = {14'h0000, s.acy_err, s.acy_busy, s.acy_rdata};
			REG_FRAMES:     read_reg = {16'h0000, s.frames};
			default:        read_reg = 32'h0000_0000;
		endcase
	endfunction : read_reg

	// ======================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.m_valid = 1'b0;
		nxt_st.m_first = 1'b0;
		nxt_st.acy_req = 1'b0;
		nxt_st.a_wr    = 1'b0;

		// ahb address phase; zero wait states, data ready for the data phase
		if (hsel && htrans[1] && hready) begin
			nxt_st.a_wr   = hwrite;
			nxt_st.a_addr = haddr[7:0];
			if (!hwrite) begin
				nxt_st.rdata = read_reg(st_ff, haddr[7:0]);
			end
		end
		// ahb data phase of a write
		if (st_ff.a_wr) begin
			case (st_ff.a_addr)
				REG_CMD:       nxt_st.cmd = hwdata[15:0];
				REG_ACY_ADDR:  nxt_st.acy_addr = hwdata[23:0];
				REG_ACY_WDATA: nxt_st.acy_wdata = hwdata[15:0];
				REG_ACY_CTRL: begin
					// a start while busy is dropped; software polls busy first
					if (hwdata[0] && !st_ff.acy_busy) begin
						nxt_st.acy_req  = 1'b1;
						nxt_st.acy_wr   = hwdata[1];
						nxt_st.acy_busy = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (st_ff.acy_busy && link.acy_ack) begin
			nxt_st.acy_busy  = 1'b0;
			nxt_st.acy_err   = link.acy_err;
			nxt_st.acy_rdata = link.acy_rdata;
		end

		// cycle timer and command transmission, high byte first
		if (st_ff.send_lo) begin
			nxt_st.m_valid = 1'b1;
			nxt_st.m_byte  = st_ff.lo_byte;
			nxt_st.send_lo = 1'b0;
		end
		if (st_ff.timer == 16'h0000) begin
			nxt_st.timer   = 16'(CYCLE_CLKS - 1);
			nxt_st.m_valid = 1'b1;
			nxt_st.m_first = 1'b1;
			nxt_st.m_byte  = st_ff.cmd[15:8] & ~CMD_RSVD_MASK[15:8];
			nxt_st.send_lo = 1'b1;
			// low byte frozen with the high byte so a write between them cannot tear
			nxt_st.lo_byte = st_ff.cmd[7:0];
			nxt_st.rx_cnt  = 2'd0;
		end else begin
			nxt_st.timer = st_ff.timer - 16'h0001;
		end

		// status reception, high byte first
		if (link.d2m_valid) begin
			if (st_ff.rx_cnt == 2'd3) begin
				nxt_st.status = {st_ff.rx_shift, link.d2m_byte} & ~STS_RSVD_MASK;
				nxt_st.frames = st_ff.frames + 16'h0001;
			end else begin
				nxt_st.rx_shift = {st_ff.rx_shift[15:0], link.d2m_byte};
			end
			nxt_st.rx_cnt = st_ff.rx_cnt + 2'd1;
		end
	end

	// ======================================================
	// registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_ff     <= '0;
			st_ff.cmd <= CMD_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================
	// outputs
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = st_ff.rdata;
	assign link.m2d_valid = st_ff.m_valid;
	assign link.m2d_first = st_ff.m_first;
	assign link.m2d_byte  = st_ff.m_byte;
	assign link.acy_req   = st_ff.acy_req;
	assign link.acy_wr    = st_ff.acy_wr;
	assign link.acy_index = st_ff.acy_addr[23:8];
	assign link.acy_sub   = st_ff.acy_addr[7:0];
	assign link.acy_wdata = st_ff.acy_wdata;
endmodule : gpdi_master

// File: bench/gpdi_chk.sv
`timescale 1ns/100ps
// ==========
// link checker
module gpdi_chk
	import gpdi_pkg::*;
(
	// clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// cyclic link
	input wire logic        m2d_valid,
	input wire logic        m2d_first,
	input wire logic [7:0]  m2d_byte,
	input wire logic        d2m_valid,
	// acyclic link
	input wire logic        acy_req,
	input wire logic        acy_wr,
	input wire logic [15:0] acy_index,
	input wire logic [7:0]  acy_sub,
	input wire logic        acy_ack,
	input wire logic        acy_err,
	input wire logic [15:0] acy_rdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_pair; m2d_valid && m2d_first |=> m2d_valid && !m2d_first; endproperty
	a_pair: assert property (p_pair) else $error("low command byte missing");
	property p_rsvd; m2d_valid && m2d_first |-> m2d_byte[7:2] == 6'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved command bits sent");
	property p_sts; m2d_valid && !m2d_first |-> ##2 d2m_valid [*4] ##1 !d2m_valid; endproperty
	a_sts: assert property (p_sts) else $error("status not four bytes");
	property p_gap; m2d_valid && m2d_first |=> !m2d_first [*7]; endproperty
	a_gap: assert property (p_gap) else $error("frames too close");
	property p_ack; acy_req |=> acy_ack; endproperty
	a_ack: assert property (p_ack) else $error("acyclic answer late");
	property p_noack; !acy_req |=> !acy_ack; endproperty
	a_noack: assert property (p_noack) else $error("stray acyclic answer");
	property p_sysrd; acy_req && !acy_wr && acy_index == IDX_SYSCMD |=> acy_err; endproperty
	a_sysrd: assert property (p_sysrd) else $error("command index readable");
	property p_grip;
		acy_req && acy_index[15:2] == IDX_GRIP_BASE[15:2]
		&& (acy_sub == SUB_FIRST || acy_sub == SUB_SECOND) |=> !acy_err;
	endproperty
	a_grip: assert property (p_grip) else $error("grip limit refused");
	property p_hold; !acy_ack |-> $stable(acy_rdata) && $stable(acy_err); endproperty
	a_hold: assert property (p_hold) else $error("answer changed without ack");
	c_err: cover property (acy_ack && acy_err);
	c_wr: cover property (acy_req && acy_wr);
	c_frame: cover property (m2d_valid && !m2d_first ##2 d2m_valid);
endmodule : gpdi_chk

// File: bench/test_gripper_process_data_interface.sv
`timescale 1ns/100ps
// ==========
// bench top
module test_gripper_process_data_interface
	import gpdi_pkg::*;
;
	logic               clock = 0, resetn = 0, hsel = 0, hwrite = 0;
	logic [31:0]        haddr = 0, hwdata = 0, hrdata, q, r;
	logic [1:0]         htrans = 0, grip_set;
	logic               hreadyout, hresp, valves_enable, grip_request, nvm_store_req;
	logic signed [15:0] jaw_pos = 0, temp_dc = 16'sh00FA, p = 0;
	logic               jaw_blocked = 0, fault_active = 0, grip_cycle_done = 0, nvm_load = 0;
	logic               en = 0, gr = 0, bk = 0, fl = 0, tw = 0, te = 0, svc = 0;
	logic [15:0]        set_nopart_limit, set_release_limit;
	logic [255:0]       param_image, img, nvm_image = 0;
	logic signed [15:0] np[4] = '{default: 16'sh0064};
	int                 err_count = 0, checks = 0, stores = 0, cur_set = 0, i;
	int                 pc[3] = '{100, 1100, -100};
	int                 tt[11] = '{250, 551, 540, 530, -1, 15, 20, 701, 690, 679, 530};
	logic [1:0]         tf[11] = '{0, 2, 2, 0, 2, 2, 0, 3, 3, 2, 0};
	gpdi_if gpdi_if_inst ();
	gpdi_master #(.CYCLE_CLKS(16)) gpdi_master_inst (.clock(clock), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .link(gpdi_if_inst));
	gpdi_device #(.SERVICE_INTERVAL(3)) gpdi_device_inst (.clock(clock), .resetn(resetn),
		.link(gpdi_if_inst), .jaw_pos(jaw_pos), .jaw_blocked(jaw_blocked),
		.temp_dc(temp_dc), .fault_active(fault_active), .grip_cycle_done(grip_cycle_done),
		.valves_enable(valves_enable), .grip_request(grip_request), .grip_set(grip_set),
		.set_nopart_limit(set_nopart_limit), .set_release_limit(set_release_limit),
		.nvm_load(nvm_load), .nvm_image(nvm_image), .nvm_store_req(nvm_store_req),
		.param_image(param_image));
	gpdi_chk gpdi_chk_inst (.clock(clock), .resetn(resetn),
		.m2d_valid(gpdi_if_inst.m2d_valid), .m2d_first(gpdi_if_inst.m2d_first),
		.m2d_byte(gpdi_if_inst.m2d_byte), .d2m_valid(gpdi_if_inst.d2m_valid),
		.acy_req(gpdi_if_inst.acy_req), .acy_wr(gpdi_if_inst.acy_wr),
		.acy_index(gpdi_if_inst.acy_index), .acy_sub(gpdi_if_inst.acy_sub),
		.acy_ack(gpdi_if_inst.acy_ack), .acy_err(gpdi_if_inst.acy_err),
		.acy_rdata(gpdi_if_inst.acy_rdata));
	always #12.5 clock = ~clock;
	always @(posedge clock) if (nvm_store_req === 1'b1) stores++;
	// ==========
	// helpers
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	// bounded wait: a stuck slave ends the run
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			conclude();
		end
	endtask : rdy
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		rdy();
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask : wr
	task automatic acy(input logic [15:0] ix, input logic [7:0] sb, input logic w,
		input logic [15:0] d);
		int n;
		wr(REG_ACY_ADDR, {8'h00, ix, sb});
		wr(REG_ACY_WDATA, {16'h0000, d});
		wr(REG_ACY_CTRL, {30'h0000_0000, w, 1'b1});
		n = 0;
		do begin
			xfer(0, REG_ACY_RESULT, 0);
			n++;
		end while (q[16] !== 1'b0 && n < 20);
		r = q;
		if (n >= 20) begin
			err_count++;
			conclude();
		end
	endtask : acy
	task automatic aerr(input logic [15:0] ix, input logic [7:0] sb, input logic w,
		input logic [15:0] d);
		acy(ix, sb, w, d);
		chk("acyclic error", 1, r[17]);
	endtask : aerr
	function automatic logic [31:0] exp_sts();
		logic [31:0] s;
		s = {p, 16'h0000};
		s[15:12] = {4{p >= -100 && p <= 100}};
		s[7:4] = {svc, tw, te, fl};
		if (!en) s[0] = 1;
		else if (gr) s[3:2] = {bk && p > np[cur_set] && p < 1100, p <= np[cur_set]};
		else s[1] = p >= 1100;
		return s;
	endfunction : exp_sts
	// snapshot is taken live, so callers let three frames pass first
	task automatic sts;
		xfer(0, REG_STATUS, 0);
		chk("status", exp_sts(), q);
		chk("resp", 0, hresp);
	endtask : sts
	task automatic pulse(input int n);
		repeat (n) begin
			grip_cycle_done <= 1;
			@(posedge clock);
			grip_cycle_done <= 0;
			@(posedge clock);
		end
		tick(48);
	endtask : pulse
	// ==========
	// main sequence
	initial begin
		void'($urandom(32'h0000_1E45));
		repeat (6) @(posedge clock);
		resetn <= 1;
		@(posedge clock);
		for (i = 0; i < 12; i++) begin
			{en, gr, bk, fl} = 4'($urandom);
			p = (i < 3) ? 16'(pc[i]) : 16'($urandom_range(1400)) - 16'sd200;
			jaw_pos <= p;
			jaw_blocked <= bk;
			fault_active <= fl;
			wr(REG_CMD, {16'h0000, 6'($urandom), en, gr, 8'h00});
			tick(48);
			sts();
			chk("valves", en, valves_enable);
			chk("grip", en & gr, grip_request);
		end
		$display("random commands done");
		en = 0;
		wr(REG_CMD, 0);
		for (i = 0; i < 11; i++) begin
			temp_dc <= 16'(tt[i]);
			{tw, te} = tf[i];
			tick(48);
			sts();
		end
		$display("temperature done");
		pulse(2);
		sts();
		pulse(1);
		svc = 1;
		sts();
		acy(IDX_SYSCMD, 8'h00, 1, {8'h00, SYSCMD_SERVICE_ACK});
		svc = 0;
		pulse(2);
		sts();
		$display("service done");
		acy(IDX_GRIP_BASE + 16'h0001, SUB_FIRST, 1, 16'h012C);
		chk("old limit", {2'b00, NOPART_DFLT}, r[17:0]);
		np[1] = 16'sh012C;
		acy(IDX_GRIP_BASE + 16'h0001, SUB_FIRST, 0, 0);
		chk("limit", 18'h0_012C, r[17:0]);
		aerr(IDX_SYSCMD, 8'h00, 0, 0);
		aerr(16'h0050, SUB_FIRST, 0, 0);
		aerr(IDX_DIAG, SUB_TEMP, 1, 0);
		aerr(IDX_SYSCMD, 8'h00, 1, 16'h0055);
		acy(IDX_DIAG, SUB_TEMP, 0, 0);
		chk("temp", 18'h0_0212, r[17:0]);
		acy(IDX_SYSCMD, 8'h00, 1, {8'h00, SYSCMD_STORE});
		chk("store", 1, stores);
		chk("image", 16'h012C, param_image[223:208]);
		$display("acyclic done");
		{en, gr, bk, p} = {3'b101, 16'sh00FA};
		jaw_pos <= p;
		jaw_blocked <= bk;
		for (i = 0; i < 2; i++) begin
			wr(REG_CMD, {22'h00_0000, 2'b10, 8'(1 + 6 * i)});
			tick(48);
			wr(REG_CMD, {22'h00_0000, 2'b11, 8'(1 + 6 * i)});
			tick(48);
			{gr, cur_set} = {1'b1, 32'sd1};
			chk("set", 1, grip_set);
			chk("set limit", 16'h012C, set_nopart_limit);
			chk("set release", {16'h0000, RELEASE_DFLT}, set_release_limit);
			sts();
		end
		$display("grip select done");
		// a parameter download replaces every stored limit and switch
		for (i = 0; i < 8; i++) img[32 * i +: 32] = $urandom;
		nvm_image <= img;
		nvm_load <= 1;
		tick(1);
		nvm_load <= 0;
		tick(1);
		for (i = 0; i < 8; i++) chk("load", img[32 * i +: 32], param_image[32 * i +: 32]);
		$display("download done");
		resetn <= 0;
		tick(2);
		resetn <= 1;
		tick(2);
		chk("reset limit", {16'h0000, NOPART_DFLT}, set_nopart_limit);
		chk("reset valves", 0, valves_enable);
		$display("reset done");
		conclude();
	end
endmodule : test_gripper_process_data_interface
